// ==== rtl/slw_link_watchdog.sv ====
// module: serial receive checker, link status, inactivity watchdog, switch fallback
`timescale 1ns/100ps
module slw_link_watchdog #(
   parameter int CW = 20,
   parameter int TW = 26,
   parameter int unsigned WD_BASE_CYC = slw_pkg::WD_BASE_CYC,
   parameter int unsigned TIMEOUT_CYC = slw_pkg::TIMEOUT_CYC
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // serial link
   input wire logic rx_i,
   input wire logic [5:0] dev_id_i,
   // switch control
   input wire logic [11:0] pwm_switch_i,
   output logic [11:0] switch_o,
   // status
   output logic fault_out_n_o,
   output logic [15:0] link_status_o,
   output logic [15:0] gen_status_o
);
   slw_pkg::slw_state_t state_ff;
   logic rx_q_ff;
   logic [CW-1:0] cyc_ff, samp_ff, bitlen_ff, r1_ff, f2_ff, r3_ff;
   logic [1:0] ecnt_ff;
   logic [3:0] bidx_ff;
   logic [2:0] fidx_ff, crc_ff, crc_fin, wd_code;
   logic is_sync_ff, par_ff, stop1_ff;
   logic [7:0] shreg_ff, addr_ff, regad_ff, dlo_ff, wr_addr_ff;
   logic [8:0] evt_ff, cfg_ff;
   logic wr_ff, tmr_load_ff, mask_ff, wd_set, fb_active;
   logic [15:0] wr_data_ff;
   logic [TW-1:0] tmr_lim_ff, wd_cnt_ff, gap_lim, wd_lim;
   logic [11:0] fallback_ff;
   logic [8:1] status_ff, w1c;
   slw_tmr_if #(.TW(TW)) tmr_if ();
   // check code step, LSB first, x^3 + x + 1
   function automatic logic [2:0] crc_step(input logic [2:0] crc, input logic [7:0] data,
                                           input int nbits);
      logic [2:0] c;
      logic fb;
      c = crc;
      fb = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < nbits) begin
            fb = c[2] ^ data[i];
            c = {c[1], c[0] ^ fb, fb};
         end
      end
      return c;
   endfunction : crc_step
   // edge time within half a bit of its nominal place
   function automatic logic in_win(input logic [CW-1:0] t, input logic [CW-1:0] mid,
                                   input logic [CW-1:0] tol);
      return (t > mid - tol) && (t < mid + tol);
   endfunction : in_win
   // line edges and derived conditions
   logic rx_fall, rx_edge, sync_ok, stop_ok, par_ok, last_frame, wr_hit, gap_over;
   logic [5:0] cluster_id;
   assign rx_fall = rx_q_ff & ~rx_i;
   assign rx_edge = rx_q_ff ^ rx_i;
   assign sync_ok = in_win(r1_ff, cyc_ff >> 3, cyc_ff >> 4) &&
                    in_win(f2_ff, cyc_ff >> 2, cyc_ff >> 4) &&
                    in_win(r3_ff, cyc_ff >> 1, cyc_ff >> 4);
   assign stop_ok = stop1_ff & rx_i;
   assign par_ok = (par_ff == ^shreg_ff);
   assign last_frame = (fidx_ff == slw_pkg::READ_LAST_FRAME && addr_ff[0]) ||
                       fidx_ff == slw_pkg::WRITE_LAST_FRAME;
   assign crc_fin = crc_step(crc_ff, shreg_ff, 5);
   assign cluster_id = cfg_ff[slw_pkg::CFG_CID_LSB +: 6];
   assign wr_hit = !addr_ff[0] && ((!addr_ff[7] && addr_ff[6:1] == dev_id_i) ||
                   (addr_ff[7] && (addr_ff[6:1] == 6'h00 || addr_ff[6:1] == cluster_id)));
   assign gap_lim = TW'({bitlen_ff, 4'h0});
   assign gap_over = TW'(cyc_ff) > gap_lim;
   assign wd_code = cfg_ff[slw_pkg::CFG_WD_LSB +: 3];
   assign wd_lim = TW'(WD_BASE_CYC) << (wd_code - 3'h1);
   assign wd_set = wd_code != 3'h0 && wd_cnt_ff > wd_lim;
   assign fb_active = status_ff[slw_pkg::ST_WATCHDOG] ||
                      (status_ff[slw_pkg::ST_GAP] && wd_code != 3'h0);
   assign w1c = (wr_ff && wr_addr_ff == slw_pkg::ADDR_LINK_STATUS) ? wr_data_ff[8:1] : 8'h00;
   // previous line level
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) rx_q_ff <= 1'b1;
      else if (ce_i) rx_q_ff <= rx_i;
   end
   // receiver: sync measure, bit sampling, packet checks, timeouts
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_ff <= slw_pkg::ST_IDLE;
         cyc_ff <= '0; samp_ff <= '0; bitlen_ff <= '0;
         r1_ff <= '0; f2_ff <= '0; r3_ff <= '0;
         ecnt_ff <= 2'h0; bidx_ff <= 4'h0; fidx_ff <= 3'h0;
         is_sync_ff <= 1'b0; par_ff <= 1'b0; stop1_ff <= 1'b0;
         shreg_ff <= 8'h00; addr_ff <= 8'h00; regad_ff <= 8'h00; dlo_ff <= 8'h00;
         crc_ff <= 3'h0; evt_ff <= 9'h000;
         wr_ff <= 1'b0; wr_addr_ff <= 8'h00; wr_data_ff <= 16'h0000;
         tmr_load_ff <= 1'b0; tmr_lim_ff <= '0;
      end else if (ce_i) begin
         evt_ff <= 9'h000;
         wr_ff <= 1'b0;
         tmr_load_ff <= 1'b0;
         if (cyc_ff != '1) cyc_ff <= cyc_ff + 1'b1;
         case (state_ff)
            slw_pkg::ST_IDLE: begin
               if (rx_fall) begin
                  state_ff <= slw_pkg::ST_SYNC;
                  cyc_ff <= CW'(1);
                  ecnt_ff <= 2'h0;
               end
            end
            slw_pkg::ST_SYNC: begin
               if (rx_edge) begin
                  ecnt_ff <= ecnt_ff + 2'h1;
                  case (ecnt_ff)
                     2'h0: r1_ff <= cyc_ff;
                     2'h1: f2_ff <= cyc_ff;
                     2'h2: r3_ff <= cyc_ff;
                     default: begin
                        bitlen_ff <= cyc_ff >> 3;
                        samp_ff <= {cyc_ff[CW-1:3], 3'h0} + (cyc_ff >> 4);
                        bidx_ff <= slw_pkg::IDX_D7;
                        shreg_ff <= {slw_pkg::SYNC_BYTE[6:0], 1'b0};
                        is_sync_ff <= 1'b1;
                        if (sync_ok) begin
                           state_ff <= slw_pkg::ST_FRAME;
                        end else begin
                           state_ff <= slw_pkg::ST_HOLD;
                           tmr_load_ff <= 1'b1;
                           tmr_lim_ff <= TW'(TIMEOUT_CYC);
                        end
                     end
                  endcase
               end else if (cyc_ff == '1) begin
                  state_ff <= slw_pkg::ST_IDLE;
               end
            end
            slw_pkg::ST_FRAME: begin
               if (cyc_ff == samp_ff) begin
                  samp_ff <= samp_ff + bitlen_ff;
                  bidx_ff <= bidx_ff + 4'h1;
                  if (bidx_ff == slw_pkg::IDX_START) begin
                     if (rx_i) begin
                        evt_ff[slw_pkg::ST_PL_START] <= 1'b1;
                        state_ff <= slw_pkg::ST_IDLE;
                     end
                  end else if (bidx_ff <= slw_pkg::IDX_D7) begin
                     shreg_ff <= {rx_i, shreg_ff[7:1]};
                  end else if (bidx_ff == slw_pkg::IDX_PARITY) begin
                     par_ff <= rx_i;
                  end else if (bidx_ff == slw_pkg::IDX_STOP1) begin
                     stop1_ff <= rx_i;
                  end else if (is_sync_ff) begin
                     evt_ff[slw_pkg::ST_SYNC_PAR] <= !par_ok;
                     evt_ff[slw_pkg::ST_SYNC_STOP] <= !stop_ok;
                     if (!par_ok || !stop_ok || shreg_ff != slw_pkg::SYNC_BYTE) begin
                        state_ff <= slw_pkg::ST_HOLD;
                        tmr_load_ff <= 1'b1;
                        tmr_lim_ff <= TW'(TIMEOUT_CYC);
                     end else begin
                        state_ff <= slw_pkg::ST_GAPW;
                        cyc_ff <= CW'(1);
                        fidx_ff <= 3'h1;
                        crc_ff <= 3'h0;
                     end
                  end else if (!par_ok || !stop_ok) begin
                     evt_ff[slw_pkg::ST_PL_PAR] <= !par_ok;
                     evt_ff[slw_pkg::ST_PL_STOP] <= !stop_ok;
                     state_ff <= slw_pkg::ST_IDLE;
                  end else if (last_frame) begin
                     if (crc_fin != shreg_ff[7:5]) begin
                        evt_ff[slw_pkg::ST_CRC] <= 1'b1;
                     end else if (wr_hit) begin
                        wr_ff <= 1'b1;
                        wr_addr_ff <= regad_ff;
                        wr_data_ff <= {3'h0, shreg_ff[4:0], dlo_ff};
                     end
                     state_ff <= slw_pkg::ST_IDLE;
                  end else begin
                     case (fidx_ff)
                        3'h1: addr_ff <= shreg_ff;
                        3'h2: regad_ff <= shreg_ff;
                        default: dlo_ff <= shreg_ff;
                     endcase
                     crc_ff <= crc_step(crc_ff, shreg_ff, 8);
                     fidx_ff <= fidx_ff + 3'h1;
                     state_ff <= slw_pkg::ST_GAPW;
                     cyc_ff <= CW'(1);
                  end
               end
            end
            slw_pkg::ST_GAPW: begin
               if (rx_fall) begin
                  state_ff <= slw_pkg::ST_FRAME;
                  cyc_ff <= CW'(1);
                  samp_ff <= bitlen_ff >> 1;
                  bidx_ff <= slw_pkg::IDX_START;
                  is_sync_ff <= 1'b0;
               end else if (gap_over) begin
                  evt_ff[slw_pkg::ST_GAP] <= 1'b1;
                  state_ff <= slw_pkg::ST_HOLD;
                  tmr_load_ff <= 1'b1;
                  tmr_lim_ff <= gap_lim;
               end
            end
            slw_pkg::ST_HOLD: begin
               if (rx_edge) begin
                  tmr_load_ff <= 1'b1;
               end else if (tmr_if.done) begin
                  state_ff <= slw_pkg::ST_IDLE;
               end
            end
            default: state_ff <= slw_pkg::ST_IDLE;
         endcase
      end
   end
   assign tmr_if.load = tmr_load_ff;
   assign tmr_if.limit = tmr_lim_ff;
   // timeout timer
   slw_timer #(.TW(TW)) u_timer (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .tmr(tmr_if.timer)
   );
   // configuration registers written by accepted packets
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_ff <= slw_pkg::LINK_CONFIG_RST;
         fallback_ff <= slw_pkg::FALLBACK_RST;
         mask_ff <= slw_pkg::MASK_RST;
      end else if (ce_i && wr_ff) begin
         case (wr_addr_ff)
            slw_pkg::ADDR_LINK_CONFIG: cfg_ff <= wr_data_ff[8:0];
            slw_pkg::ADDR_FALLBACK: fallback_ff <= wr_data_ff[11:0];
            slw_pkg::ADDR_MASK_GEN: mask_ff <= wr_data_ff[slw_pkg::MSK_LINK_ERR_BIT];
            default: ;
         endcase
      end
   end
   // inactivity counter, reset by any line edge
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) wd_cnt_ff <= '0;
      else if (ce_i) begin
         if (wd_code == 3'h0 || rx_edge || wd_set) wd_cnt_ff <= '0;
         else if (wd_cnt_ff != '1) wd_cnt_ff <= wd_cnt_ff + 1'b1;
      end
   end
   // sticky link status, set wins over write-one-to-clear
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) status_ff <= 8'h00;
      else if (ce_i) status_ff <= (status_ff & ~w1c) | {wd_set, evt_ff[7:1]};
   end
   // registered outputs
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         switch_o <= 12'h000;
         fault_out_n_o <= 1'b1;
         link_status_o <= 16'h0000;
         gen_status_o <= 16'h0000;
      end else if (ce_i) begin
         switch_o <= fb_active ? fallback_ff : pwm_switch_i;
         fault_out_n_o <= !((|status_ff) && !mask_ff);
         link_status_o <= {7'h00, status_ff, 1'b0};
         gen_status_o <= 16'(|status_ff) << slw_pkg::GEN_LINK_ERR_BIT;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   AST_WD_SET_ON_IDLE: assert property (
      (ce_i && wd_code != 3'h0 && wd_cnt_ff > wd_lim) |=> status_ff[slw_pkg::ST_WATCHDOG])
      else $error("watchdog flag not set after idle period");
   AST_FALLBACK_DRIVE: assert property (
      (ce_i && status_ff[slw_pkg::ST_WATCHDOG]) |=> switch_o == $past(fallback_ff))
      else $error("switches not at fallback pattern");
   AST_MASK_HOLDS_FAULT: assert property ((ce_i && mask_ff) |=> fault_out_n_o)
      else $error("masked link fault reached fault output");
   AST_FAULT_ON_ERROR: assert property (
      (ce_i && (|status_ff) && !mask_ff) |=> !fault_out_n_o)
      else $error("fault output not asserted");
   AST_RESUME_DIMMING: assert property (
      (ce_i && !fb_active) |=> switch_o == $past(pwm_switch_i))
      else $error("switches not following dimming values");
   AST_W1C_CLEARS: assert property (
      (ce_i && w1c[slw_pkg::ST_CRC] && !evt_ff[slw_pkg::ST_CRC]) |=> !status_ff[slw_pkg::ST_CRC])
      else $error("write one did not clear status bit");
   AST_SYNC_STOP_HOLD: assert property (
      (ce_i && state_ff == slw_pkg::ST_FRAME && is_sync_ff && cyc_ff == samp_ff &&
       bidx_ff == slw_pkg::IDX_STOP2 && !stop_ok)
      |=> state_ff == slw_pkg::ST_HOLD && tmr_lim_ff == TW'(TIMEOUT_CYC) && tmr_if.load)
      else $error("sync stop error did not start long timeout");
   AST_GAP_HOLD: assert property (
      (ce_i && state_ff == slw_pkg::ST_GAPW && !rx_fall && gap_over)
      |=> state_ff == slw_pkg::ST_HOLD && tmr_lim_ff == $past(gap_lim) && evt_ff[slw_pkg::ST_GAP])
      else $error("gap did not start short timeout");
   AST_PL_REARM: assert property (
      (ce_i && state_ff == slw_pkg::ST_FRAME && !is_sync_ff && cyc_ff == samp_ff &&
       bidx_ff == slw_pkg::IDX_STOP2 && !stop_ok)
      |=> state_ff == slw_pkg::ST_IDLE && evt_ff[slw_pkg::ST_PL_STOP])
      else $error("payload stop error did not rearm");
   AST_HOLD_RESTART: assert property (
      (ce_i && state_ff == slw_pkg::ST_HOLD && rx_edge) |=> tmr_load_ff)
      else $error("activity in timeout did not restart it");
   AST_WD_DISABLED: assert property (
      (ce_i && wd_code == 3'h0) |=> wd_cnt_ff == '0 && !status_ff[slw_pkg::ST_WATCHDOG] ||
      $past(status_ff[slw_pkg::ST_WATCHDOG]))
      else $error("watchdog ran while disabled");
   COV_SYNC_OK: cover property (state_ff == slw_pkg::ST_SYNC ##1 state_ff == slw_pkg::ST_FRAME);
   COV_WRITE: cover property (wr_ff && wr_addr_ff == slw_pkg::ADDR_LINK_CONFIG);
   COV_GAP: cover property (evt_ff[slw_pkg::ST_GAP]);
   COV_WATCHDOG: cover property (wd_set);
endmodule : slw_link_watchdog

// ==== rtl/slw_pkg.sv ====
// package: constants and types of the serial link error watchdog
package slw_pkg;
   localparam int CLK_PERIOD_NS = 4;
   // register offsets
   localparam logic [7:0] ADDR_LINK_CONFIG = 8'h07;
   localparam logic [7:0] ADDR_FALLBACK = 8'h08;
   localparam logic [7:0] ADDR_MASK_GEN = 8'h0C;
   localparam logic [7:0] ADDR_GEN_STATUS = 8'h10;
   localparam logic [7:0] ADDR_LINK_STATUS = 8'h11;
   // field positions
   localparam int CFG_WD_LSB = 6;
   localparam int CFG_CID_LSB = 0;
   localparam int MSK_LINK_ERR_BIT = 6;
   localparam int GEN_LINK_ERR_BIT = 6;
   localparam int ST_PL_START = 1;
   localparam int ST_PL_STOP = 2;
   localparam int ST_SYNC_STOP = 3;
   localparam int ST_PL_PAR = 4;
   localparam int ST_SYNC_PAR = 5;
   localparam int ST_CRC = 6;
   localparam int ST_GAP = 7;
   localparam int ST_WATCHDOG = 8;
   // reset values
   localparam logic [8:0] LINK_CONFIG_RST = 9'h000;
   localparam logic [11:0] FALLBACK_RST = 12'h000;
   localparam logic MASK_RST = 1'b0;
   // frame format: start, 8 data, even parity, 2 stops
   localparam logic [7:0] SYNC_BYTE = 8'h79;
   localparam logic [3:0] IDX_START = 4'h0;
   localparam logic [3:0] IDX_D7 = 4'h8;
   localparam logic [3:0] IDX_PARITY = 4'h9;
   localparam logic [3:0] IDX_STOP1 = 4'hA;
   localparam logic [3:0] IDX_STOP2 = 4'hB;
   localparam logic [2:0] READ_LAST_FRAME = 3'h3;
   localparam logic [2:0] WRITE_LAST_FRAME = 3'h4;
   localparam int GAP_BITS_SHIFT = 4;
   // timing
   localparam int TIMEOUT_MS = 35;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int WD_BASE_MS = 1;
   localparam int WD_BASE_CYC = WD_BASE_MS * 1000000 / CLK_PERIOD_NS;
   // receiver states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SYNC = 3'b001,
      ST_FRAME = 3'b010,
      ST_GAPW = 3'b011,
      ST_HOLD = 3'b100
   } slw_state_t;
endpackage : slw_pkg

// ==== rtl/slw_tmr_if.sv ====
// interface: request and expiry of the receive timeout timer
`timescale 1ns/100ps
interface slw_tmr_if #(parameter int TW = 26);
   logic load;
   logic [TW-1:0] limit;
   logic done;
   modport owner (output load, output limit, input done);
   modport timer (input load, input limit, output done);
endinterface : slw_tmr_if

// ==== rtl/slw_timer.sv ====
// module: reloadable countdown timer for receive timeouts
`timescale 1ns/100ps
module slw_timer #(
   parameter int TW = 26
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // timer control
   slw_tmr_if.timer tmr
);
   logic [TW-1:0] cnt_ff;
   logic run_ff;
   logic done_ff;

   // a load restarts the full period, expiry gives a one-cycle done
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_ff <= '0;
         run_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (ce_i) begin
         done_ff <= 1'b0;
         if (tmr.load) begin
            cnt_ff <= tmr.limit;
            run_ff <= 1'b1;
         end else if (run_ff) begin
            if (cnt_ff <= TW'(1)) begin
               run_ff <= 1'b0;
               done_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - 1'b1;
            end
         end
      end
   end

   assign tmr.done = done_ff;
endmodule : slw_timer

// ==== verif/slw_host_model.sv ====
// host model: drives packets on the serial receive line
`timescale 1ns/100ps
module slw_host_model #(parameter int T = 16) (
   // clock
   input wire logic clk_i,
   // serial line, idle high
   output logic rx_o
);
   logic [2:0] crc;
   // line rests high
   initial rx_o = 1'b1;
   // hold a level for n cycles from the current edge
   task automatic drive(input logic v, input int n);
      rx_o <= v;
      repeat (n) @(posedge clk_i);
   endtask : drive
   // one frame lsb first; err bit0 parity, bit1 stop low, bit2 start glitch
   task automatic frame(input logic [7:0] b, input logic [2:0] err);
      logic [11:0] f;
      f = {1'b1, ~err[1], (^b) ^ err[0], b, 1'b0};
      if (err[2]) begin
         drive(1'b0, T / 4);
         drive(1'b1, 12 * T - T / 4);
      end else begin
         for (int i = 0; i < 12; i++) drive(f[i], T);
      end
   endtask : frame
   // check code step, lsb first
   task automatic crc_add(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) crc = {crc[1], crc[0] ^ crc[2] ^ b[i], crc[2] ^ b[i]};
   endtask : crc_add
   // write packet; k: 0 good, 1 check, 2 parity, 3 stop, 4 start, 5/6 sync, 7 gap
   task automatic pkt(input logic [7:0] a, input logic [7:0] r, input logic [12:0] v,
                      input int k);
      crc = 3'h0;
      crc_add(a, 8);
      crc_add(r, 8);
      crc_add(v[7:0], 8);
      crc_add({3'h0, v[12:8]}, 5);
      frame(slw_pkg::SYNC_BYTE, (k == 5) ? 3'h2 : ((k == 6) ? 3'h1 : 3'h0));
      if (k < 5 || k == 7) frame(a, 3'h0);
      if (k == 7) drive(1'b1, 20 * T);
      if (k < 5) begin
         frame(r, 3'h0);
         frame(v[7:0], 3'h0);
         frame({crc ^ {2'h0, k == 1}, v[12:8]}, (k > 1) ? 3'(1 << (k - 2)) : 3'h0);
      end
   endtask : pkt
endmodule : slw_host_model

// ==== verif/tb_top.sv ====
// testbench: watchdog, fallback, mask and receive error handling
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
   logic clk_i = 1'b0;
   logic rst_b_i;
   logic rx;
   logic [5:0] dev_id;
   logic [11:0] pwm, fb, sw;
   logic flt_n;
   logic [15:0] lst, gst;
   int bad_count = 0;
   int checked = 0;
   // design with shortened watchdog base and timeout
   slw_link_watchdog #(.WD_BASE_CYC(200), .TIMEOUT_CYC(500)) i_dut (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .ce_i(1'b1), .rx_i(rx), .dev_id_i(dev_id), .pwm_switch_i(pwm),
      .switch_o(sw), .fault_out_n_o(flt_n), .link_status_o(lst), .gen_status_o(gst));
   slw_host_model #(.T(16)) i_host (.clk_i(clk_i), .rx_o(rx));
   // 250 MHz clock
   always #2 clk_i = ~clk_i;
   // report and end the run
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   // individual write, then let the effect reach the outputs
   task automatic wr(input logic [7:0] r, input logic [12:0] v);
      i_host.pkt({1'b0, dev_id, 1'b0}, r, v, 0);
      repeat (5) @(posedge clk_i);
   endtask : wr
   // status bit expected for each error kind
   function automatic int exp_bit(input int k);
      case (k)
         1: return slw_pkg::ST_CRC;
         2: return slw_pkg::ST_PL_PAR;
         3: return slw_pkg::ST_PL_STOP;
         4: return slw_pkg::ST_PL_START;
         5: return slw_pkg::ST_SYNC_STOP;
         6: return slw_pkg::ST_SYNC_PAR;
         default: return slw_pkg::ST_GAP;
      endcase
   endfunction : exp_bit
   // main sequence
   initial begin
      int i;
      rst_b_i = 1'b0;
      void'($urandom(7));
      dev_id = 6'($urandom);
      pwm = 12'($urandom);
      fb = 12'($urandom);
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("status", 16'h0000, lst)
      `CHK("fault", 1'b1, flt_n)
      `CHK("switch", pwm, sw)
      // code 2 is longer than the packet spacing used here
      wr(8'h07, 13'h0080);
      repeat (150) @(posedge clk_i);
      `CHK("wd early", 1'b0, lst[8])
      i = 0;
      while (lst[8] !== 1'b1 && i < 600) begin
         @(posedge clk_i);
         i++;
      end
      if (i == 600) begin
         bad_count++;
         $display("[FAIL] watchdog wait exp 1 got 0");
         print_verdict();
      end
      repeat (3) @(posedge clk_i);
      `CHK("fault", 1'b0, flt_n)
      `CHK("switch", 12'h000, sw)
      wr(8'h08, {1'b0, fb});
      `CHK("switch", fb, sw)
      wr(8'h0C, 13'h0040);
      `CHK("masked", 1'b1, flt_n)
      `CHK("wd held", 1'b1, lst[8])
      pwm <= 12'($urandom);
      wr(8'h11, 13'h0100);
      `CHK("wd clear", 1'b0, lst[8])
      `CHK("switch", pwm, sw)
      wr(8'h0C, 13'h0000);
      wr(8'h07, 13'h0000);
      // every error kind, then clear; quiet wait covers any timeout
      for (int k = 1; k < 8; k++) begin
         i_host.pkt({1'b0, dev_id, 1'b0}, 8'h08, 13'h0000, k);
         repeat (5) @(posedge clk_i);
         `CHK("err bit", 1'b1, lst[exp_bit(k)])
         `CHK("fault", 1'b0, flt_n)
         `CHK("general", 1'b1, gst[6])
         `CHK("switch", pwm, sw)
         repeat (600) @(posedge clk_i);
         wr(8'h11, 13'h1FE);
         `CHK("cleared", 16'h0000, lst)
      end
      // gap flag with the watchdog enabled forces the fallback pattern
      wr(8'h07, 13'h01C0);
      i_host.pkt({1'b0, dev_id, 1'b0}, 8'h08, 13'h0000, 7);
      repeat (5) @(posedge clk_i);
      `CHK("gap fallback", fb, sw)
      repeat (600) @(posedge clk_i);
      wr(8'h11, 13'h1FE);
      `CHK("gap cleared", pwm, sw)
      wr(8'h07, 13'h0000);
      // activity inside the sync timeout restarts it
      i_host.pkt({1'b0, dev_id, 1'b0}, 8'h08, 13'h0000, 6);
      repeat (300) @(posedge clk_i);
      i_host.pkt({1'b0, dev_id, 1'b0}, 8'h08, 13'h0000, 1);
      repeat (300) @(posedge clk_i);
      i_host.pkt({1'b0, dev_id, 1'b0}, 8'h08, 13'h0000, 1);
      repeat (5) @(posedge clk_i);
      `CHK("ignored", 1'b0, lst[slw_pkg::ST_CRC])
      repeat (600) @(posedge clk_i);
      i_host.pkt({1'b0, dev_id, 1'b0}, 8'h08, 13'h0000, 1);
      repeat (5) @(posedge clk_i);
      `CHK("resumed", 1'b1, lst[slw_pkg::ST_CRC])
      print_verdict();
   end
endmodule : tb_top
